// ===== src/iopi_regs.sv
// process image register bank: inputs, outputs, fault location, diag status
`timescale 1ns/10ps
// Behaviour
// - fault location reads 0 none, 1 short
// - one code covers whole output group
// - inputs one-eight on bits 0-7
// - outputs one-four from bits 0-3
// - big-endian words mapped bit for bit
// - byte data sits in low byte
// - upper byte reads zero, writes discarded
// - connection accepted within 350 ms
// - cyclic data ready within 500 ms
// - diag status bit0 set during short
module iopi_regs #(
  parameter int CONN_CYC = iopi_pkg::CONN_READY_CYC,
  parameter int CYCLIC_CYC = iopi_pkg::CYCLIC_READY_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire iopi_pkg::iopi_req_type i_req,
  input wire logic [7:0] i_digital_input_channel,
  input wire logic [3:0] i_out_short,
  output iopi_pkg::iopi_rsp_type o_rsp,
  output logic [3:0] o_digital_output_channel,
  output logic o_conn_ready,
  output logic o_cyclic_ready
);
  // ==========================================================
  // state
  logic [7:0] in_latch; // sampled inputs
  logic [7:0] out_byte; // stored output byte, low nibble only
  logic short_any; // any output shorted
  logic [15:0] next_rdata; // read mux result
  logic next_hit; // address decoded

  // ==========================================================
  // readiness timers
  iopi_ready_timer #(.COUNT(CONN_CYC)) u_conn (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .o_ready(o_conn_ready)
  );
  iopi_ready_timer #(.COUNT(CYCLIC_CYC)) u_cyc (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .o_ready(o_cyclic_ready)
  );

  // ==========================================================
  // input sampling and fault summary
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      in_latch <= 8'h00;
      short_any <= 1'b0;
    end else begin
      in_latch <= i_digital_input_channel;
      short_any <= |i_out_short;
    end
  end

  // ==========================================================
  // output register: upper byte and bits 4-7 discarded on write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      out_byte <= 8'h00;
    end else if (i_req.wr && i_req.addr == iopi_pkg::ADDR_OUTPUT_WORD && o_cyclic_ready) begin
      out_byte <= i_req.wdata[7:0] & iopi_pkg::OUT_MASK;
    end
  end

  // drives physical outputs from bits 0-3
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_digital_output_channel <= 4'h0;
    end else begin
      o_digital_output_channel <= out_byte[3:0];
    end
  end

  // ==========================================================
  // read decode
  always_comb begin
    next_hit = 1'b1;
    if (i_req.addr == iopi_pkg::ADDR_FAULT_LOC) begin
      next_rdata = short_any ? iopi_pkg::FAULT_GROUP_OUT : iopi_pkg::FAULT_NONE;
    end else if (i_req.addr == iopi_pkg::ADDR_INPUT_WORD) begin
      next_rdata = {iopi_pkg::UPPER_BYTE_ZERO, in_latch};
    end else if (i_req.addr == iopi_pkg::ADDR_OUTPUT_WORD) begin
      next_rdata = {iopi_pkg::UPPER_BYTE_ZERO, out_byte};
    end else if (i_req.addr == iopi_pkg::ADDR_DIAG_STATUS) begin
      next_rdata = short_any ? iopi_pkg::DIAG_OUT_SHORT : iopi_pkg::ZERO_WORD;
    end else begin
      next_rdata = iopi_pkg::ZERO_WORD;
      next_hit = 1'b0;
    end
  end

  // answer one cycle after request; writes to read-only or unknown flag error
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rsp <= '0;
    end else begin
      o_rsp.ack <= (i_req.rd || i_req.wr) && o_conn_ready;
      o_rsp.err <= ((i_req.rd || i_req.wr) && o_conn_ready)
                   && (!next_hit || (i_req.wr && i_req.addr != iopi_pkg::ADDR_OUTPUT_WORD));
      o_rsp.rdata <= (i_req.rd && o_conn_ready) ? next_rdata : iopi_pkg::ZERO_WORD;
    end
  end

  // ==========================================================
  // checks
  // answers are held against the pins, not against the read mux
  // fault code follows the shorts seen two edges before the answer
  property p_fault_loc;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.rd && o_conn_ready && i_req.addr == iopi_pkg::ADDR_FAULT_LOC)
    |=> o_rsp.rdata == ($past(|i_out_short, 2) ? iopi_pkg::FAULT_GROUP_OUT
      : iopi_pkg::FAULT_NONE);
  endproperty
  a_fault_loc: assert property (p_fault_loc) else $error("fault code wrong");

  // any shorted output raises the single group flag
  property p_group;
    @(posedge i_clk_sys) disable iff (i_srst)
    (|i_out_short) |=> short_any;
  endproperty
  a_group: assert property (p_group) else $error("group fault missed");

  // input latch follows the pins one edge later
  property p_inputs;
    @(posedge i_clk_sys) disable iff (i_srst)
    1'b1 |=> in_latch == $past(i_digital_input_channel);
  endproperty
  a_inputs: assert property (p_inputs) else $error("input bits wrong");

  // input word carries the pins in the low byte, upper byte clear
  property p_input_word;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.rd && o_conn_ready && i_req.addr == iopi_pkg::ADDR_INPUT_WORD)
    |=> o_rsp.rdata == {iopi_pkg::UPPER_BYTE_ZERO, $past(i_digital_input_channel, 2)};
  endproperty
  a_input_word: assert property (p_input_word) else $error("input word wrong");

  // a live write reaches the pins two edges later
  property p_outputs;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.wr && o_cyclic_ready && i_req.addr == iopi_pkg::ADDR_OUTPUT_WORD)
    |=> ##1 o_digital_output_channel == $past(i_req.wdata[3:0], 2);
  endproperty
  a_outputs: assert property (p_outputs) else $error("output drive wrong");

  // byte-wide words never show data in the upper byte
  property p_upper_zero;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.rd && i_req.addr != iopi_pkg::ADDR_FAULT_LOC)
    |=> o_rsp.rdata[15:8] == iopi_pkg::UPPER_BYTE_ZERO;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper byte set");

  // unused output bits are never stored
  property p_hi_nibble;
    @(posedge i_clk_sys) disable iff (i_srst)
    1'b1 |-> out_byte[7:4] == iopi_pkg::OUT_MASK[7:4];
  endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("bits 4-7 stored");

  // output word reads back with bits 4-15 clear
  property p_out_readback;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.rd && o_conn_ready && i_req.addr == iopi_pkg::ADDR_OUTPUT_WORD)
    |=> o_rsp.rdata[15:8] == iopi_pkg::UPPER_BYTE_ZERO
      && o_rsp.rdata[7:4] == iopi_pkg::OUT_MASK[7:4];
  endproperty
  a_out_readback: assert property (p_out_readback) else $error("output readback wrong");

  // diag status bit 0 mirrors a short two edges before the answer
  property p_diag;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.rd && o_conn_ready && i_req.addr == iopi_pkg::ADDR_DIAG_STATUS)
    |=> o_rsp.rdata == ($past(|i_out_short, 2) ? iopi_pkg::DIAG_OUT_SHORT
      : iopi_pkg::ZERO_WORD);
  endproperty
  a_diag: assert property (p_diag) else $error("diag bit wrong");

  // cyclic readiness never comes before connection readiness
  property p_order;
    @(posedge i_clk_sys) disable iff (i_srst)
    o_cyclic_ready |-> o_conn_ready;
  endproperty
  a_order: assert property (p_order) else $error("cyclic before conn");

  // a request taken while connected is answered on the next edge
  property p_ack_taken;
    @(posedge i_clk_sys) disable iff (i_srst)
    ((i_req.rd || i_req.wr) && o_conn_ready) |=> o_rsp.ack;
  endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("request not answered");

  // nothing is answered before the connection timer runs out
  property p_no_early_ack;
    @(posedge i_clk_sys) disable iff (i_srst)
    ((i_req.rd || i_req.wr) && !o_conn_ready) |=> !o_rsp.ack;
  endproperty
  a_no_early_ack: assert property (p_no_early_ack) else $error("answer before ready");

  // connection readiness stays up once reached
  property p_conn_hold;
    @(posedge i_clk_sys) disable iff (i_srst)
    o_conn_ready |=> o_conn_ready;
  endproperty
  a_conn_hold: assert property (p_conn_hold) else $error("conn ready dropped");

  // cyclic readiness stays up once reached
  property p_cyc_hold;
    @(posedge i_clk_sys) disable iff (i_srst)
    o_cyclic_ready |=> o_cyclic_ready;
  endproperty
  a_cyc_hold: assert property (p_cyc_hold) else $error("cyclic ready dropped");

  // writes before cyclic readiness never reach the pins
  property p_cyc_block;
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_req.wr && !o_cyclic_ready) |=> ##1 $stable(o_digital_output_channel);
  endproperty
  a_cyc_block: assert property (p_cyc_block) else $error("early write drove pins");
endmodule // iopi_regs

// ===== src/iopi_pkg.sv
// package: register map, field layout and timing constants of the process image
package iopi_pkg;
  // register addresses, decimal register numbers printed in hex
  localparam logic [15:0] ADDR_FAULT_LOC = 16'h1F3E;
  localparam logic [15:0] ADDR_INPUT_WORD = 16'h1F40;
  localparam logic [15:0] ADDR_OUTPUT_WORD = 16'h2328;
  localparam logic [15:0] ADDR_DIAG_STATUS = 16'h1F3D;
  // fault location codes
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_GROUP_OUT = 16'h0001;
  // diagnostic status bit for output short circuit
  localparam logic [15:0] DIAG_OUT_SHORT = 16'h0001;
  // byte-wide data sits in the low byte; upper byte reads as zero
  localparam logic [7:0] UPPER_BYTE_ZERO = 8'h00;
  localparam logic [7:0] OUT_MASK = 8'h0F;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_OUTPUTS = 4;
  // readiness times
  localparam int CLK_HZ = 10_000_000;
  localparam int CONN_READY_MS = 350;
  localparam int CYCLIC_READY_MS = 500;
  // longest times round down to whole cycles
  localparam int CONN_READY_CYC = (CLK_HZ / 1000) * CONN_READY_MS - 1;
  localparam int CYCLIC_READY_CYC = (CLK_HZ / 1000) * CYCLIC_READY_MS - 1;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // register request from the protocol side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iopi_req_type;

  // register answer
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } iopi_rsp_type;
endpackage

// ===== src/iopi_ready_timer.sv
// power-up readiness timer
`timescale 1ns/10ps
module iopi_ready_timer #(
  parameter int COUNT = 3_499_999
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  output logic o_ready
);
  // ==========================================================
  // counter
  logic [31:0] cnt; // cycles since reset release, held at COUNT

  // counts up then holds ready high
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cnt <= 32'h0000_0000;
      o_ready <= 1'b0;
    end else if (cnt >= 32'(COUNT)) begin
      o_ready <= 1'b1;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end
endmodule // iopi_ready_timer

// ===== test/iopi_client.sv
// client model: one register request per call
`timescale 1ns/10ps
module iopi_client (
  input wire logic i_clk_sys,
  output iopi_pkg::iopi_req_type o_req
);
  // request word, idle between calls
  initial o_req = '0;
  // hold the request for one clock, then drop it
  task automatic send(input logic r, input logic [15:0] a, input logic [15:0] d);
    o_req = {r, ~r, a, d};
    @(negedge i_clk_sys);
    o_req = '0;
  endtask
endmodule // iopi_client

// ===== test/tb_top.sv
// testbench: random and corner traffic through the process image
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
  // ====================
  // signals
  logic clk = 1'b0; // 100 ns clock
  logic srst = 1'b1; // sync reset
  logic [7:0] din = 8'h00; // input pins
  logic [3:0] shorts = 4'h0; // short flags
  logic [15:0] w; // written word
  iopi_pkg::iopi_req_type req; // client request
  iopi_pkg::iopi_rsp_type rsp; // device answer
  logic [3:0] dout; // output pins
  logic conn; // connection ready
  logic cyc; // cyclic ready
  int failures = 0;
  int compares = 0;
  // clock
  always #50 clk = ~clk;
  iopi_client u_client (.i_clk_sys(clk), .o_req(req));
  iopi_regs #(.CONN_CYC(10), .CYCLIC_CYC(20)) u_iopi_regs (.i_clk_sys(clk),
    .i_srst(srst), .i_req(req), .i_digital_input_channel(din),
    .i_out_short(shorts), .o_rsp(rsp), .o_digital_output_channel(dout),
    .o_conn_ready(conn), .o_cyclic_ready(cyc));
  // ====================
  // helpers
  // expected fault code: one code for the whole group
  function automatic logic [15:0] fault_exp(input logic [3:0] s);
    return (s != 4'h0) ? iopi_pkg::FAULT_GROUP_OUT : iopi_pkg::FAULT_NONE;
  endfunction
  // expected diag status word: bit 0 flags a short anywhere
  function automatic logic [15:0] diag_exp(input logic [3:0] s);
    return (s != 4'h0) ? iopi_pkg::DIAG_OUT_SHORT : iopi_pkg::ZERO_WORD;
  endfunction
  // print counts and verdict, then stop
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // read one register and compare the answer
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic er);
    u_client.send(1'b1, a, 16'h0000);
    // the answer stands for one cycle only: look at it right away
    `CHK("ack", 1'b1, rsp.ack)
    `CHK("err", er, rsp.err)
    `CHK("rdata", e, rsp.rdata)
    // let an edge pass before the next request
    @(negedge clk);
  endtask
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end
  // ====================
  // main sequence
  initial begin
    void'($urandom(32'hEFDC));
    repeat (20) @(negedge clk);
    srst = 1'b0;
    `CHK("dout reset", 4'h0, dout)
    // request before the device is ready gets no answer
    u_client.send(1'b1, iopi_pkg::ADDR_INPUT_WORD, 16'h0000);
    `CHK("early ack", 1'b0, rsp.ack)
    `CHK("conn early", 1'b0, conn)
    @(negedge clk);
    // once connected, writes are answered but must not drive the pins yet
    while (!conn) @(negedge clk);
    `CHK("cyc early", 1'b0, cyc)
    u_client.send(1'b0, iopi_pkg::ADDR_OUTPUT_WORD, 16'h000F);
    `CHK("early wr ack", 1'b1, rsp.ack)
    repeat (2) @(negedge clk);
    `CHK("dout early", 4'h0, dout)
    // cyclic readiness follows connection readiness by ten cycles
    repeat (15) @(negedge clk);
    `CHK("conn", 1'b1, conn)
    `CHK("cyc", 1'b1, cyc)
    rd(16'h0000, 16'h0000, 1'b1);
    // corners first: all low, all high, each single short
    for (int i = 0; i < 24; i++) begin
      din = (i < 2) ? {8{i[0]}} : 8'($urandom);
      shorts = (i < 2) ? {4{i[0]}} : (i < 6) ? 4'(1 << (i - 2)) : 4'($urandom);
      w = (i < 2) ? {16{i[0]}} : 16'($urandom);
      u_client.send(1'b0, iopi_pkg::ADDR_OUTPUT_WORD, w);
      `CHK("wr ack", 1'b1, rsp.ack)
      `CHK("wr err", 1'b0, rsp.err)
      @(negedge clk);
      `CHK("dout", w[3:0], dout)
      rd(iopi_pkg::ADDR_OUTPUT_WORD, {12'h000, w[3:0]}, 1'b0);
      rd(iopi_pkg::ADDR_INPUT_WORD, {8'h00, din}, 1'b0);
      rd(iopi_pkg::ADDR_FAULT_LOC, fault_exp(shorts), 1'b0);
      rd(iopi_pkg::ADDR_DIAG_STATUS, diag_exp(shorts), 1'b0);
    end
    // a write to the read-only input word is refused and changes nothing
    u_client.send(1'b0, iopi_pkg::ADDR_INPUT_WORD, 16'hFFFF);
    `CHK("ro ack", 1'b1, rsp.ack)
    `CHK("ro err", 1'b1, rsp.err)
    @(negedge clk);
    `CHK("dout kept", w[3:0], dout)
    rd(iopi_pkg::ADDR_INPUT_WORD, {8'h00, din}, 1'b0);
    test_done();
  end
endmodule // tb_top
